// >>> design/irq_regs_pkg.sv
// shared offsets, field positions, reset values and types of the interrupt register bank
package irq_regs_pkg;

    // ------------------------------------------------------------
    // bus geometry and register byte offsets
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 5;
    localparam logic [4:0] OFS_MAIN = 5'h00;
    localparam logic [4:0] OFS_EDGES = 5'h04;
    localparam logic [4:0] OFS_EXT = 5'h08;
    localparam logic [4:0] OFS_PFLAG1 = 5'h0C;
    localparam logic [4:0] OFS_RESET_CTRL = 5'h10;

    // ------------------------------------------------------------
    // irq_control_main fields
    // ------------------------------------------------------------
    localparam int unsigned MAIN_GLOBAL_HIGH = 7;
    localparam int unsigned MAIN_PERIPH_LOW = 6;
    localparam int unsigned MAIN_TMR0_EN = 5;
    localparam int unsigned MAIN_EXT0_EN = 4;
    localparam int unsigned MAIN_PORT_EN = 3;
    localparam int unsigned MAIN_TMR0_FLAG = 2;
    localparam int unsigned MAIN_EXT0_FLAG = 1;
    localparam int unsigned MAIN_PORT_FLAG = 0;

    // ------------------------------------------------------------
    // irq_control_edges_priority fields
    // ------------------------------------------------------------
    localparam int unsigned EDG_PULLUP_DIS = 7;
    localparam int unsigned EDG_EXT0_SEL = 6;
    localparam int unsigned EDG_EXT1_SEL = 5;
    localparam int unsigned EDG_EXT2_SEL = 4;
    localparam int unsigned EDG_TMR0_PRIO = 2;
    localparam int unsigned EDG_PORT_PRIO = 0;

    // ------------------------------------------------------------
    // irq_control_external_pins fields
    // ------------------------------------------------------------
    localparam int unsigned EXT_TWO_PRIO = 7;
    localparam int unsigned EXT_ONE_PRIO = 6;
    localparam int unsigned EXT_TWO_EN = 4;
    localparam int unsigned EXT_ONE_EN = 3;
    localparam int unsigned EXT_TWO_FLAG = 1;
    localparam int unsigned EXT_ONE_FLAG = 0;

    // ------------------------------------------------------------
    // peripheral_flag_bank_one fields and reset control
    // ------------------------------------------------------------
    localparam int unsigned PF_PARALLEL = 7;
    localparam int unsigned PF_CONVERSION = 6;
    localparam int unsigned PF_RX_FULL = 5;
    localparam int unsigned PF_TX_EMPTY = 4;
    localparam int unsigned PF_SYNC_SERIAL = 3;
    localparam int unsigned PF_CAPTURE_ONE = 2;
    localparam int unsigned RC_PRIO_MODE = 7;

    // ------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_MAIN = 8'h00;
    localparam logic [7:0] RST_EDGES = 8'hF5;
    localparam logic [7:0] RST_EXT = 8'hC0;
    localparam logic [7:0] RST_PFLAG1 = 8'h00;
    localparam logic [7:0] RST_RESET_CTRL = 8'h00;
    localparam logic [7:0] WMASK_EDGES = 8'hF5;
    localparam logic [7:0] WMASK_EXT = 8'hDB;
    localparam logic [7:0] WMASK_PFLAG1 = 8'hCC;
    localparam logic [7:0] WMASK_RESET_CTRL = 8'h80;

    // ------------------------------------------------------------
    // vectors and bus state
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_HIGH = 16'h0008;
    localparam logic [15:0] VEC_LOW = 16'h0018;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_t;

endpackage

// >>> design/ext_edge_detect.sv
// selectable rising or falling edge detector for the external interrupt pins
`timescale 1ns/10ps
`default_nettype none
module ext_edge_detect #(
    parameter int unsigned NUM = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [NUM-1:0] pins_i,
    input wire logic [NUM-1:0] rising_sel_i,
    output logic [NUM-1:0] event_o
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (NUM < 1 || NUM > 8) begin : g_bad_num
        $error("ext_edge_detect: NUM must be 1 to 8");
    end

    logic [NUM-1:0] prev_q; // pin levels one cycle ago
    logic armed_q; // no edge before the first sample

    // previous level, caught after reset release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= '0;
            armed_q <= 1'b0;
        end else begin
            prev_q <= pins_i;
            armed_q <= 1'b1;
        end
    end

    // one-cycle event on the selected edge
    always_comb begin
        event_o = '0;
        if (armed_q) begin
            event_o = (rising_sel_i & ~prev_q & pins_i) | (~rising_sel_i & prev_q & ~pins_i);
        end
    end
endmodule // ext_edge_detect
`default_nettype wire

// >>> design/irq_request_arbiter.sv
// forms the high and low priority requests from pending sources and global enables
`timescale 1ns/10ps
`default_nettype none
module irq_request_arbiter #(
    parameter int unsigned NUM_CORE = 5,
    parameter int unsigned NUM_PERIPH = 8
) (
    input wire logic [NUM_CORE-1:0] core_pend_i,
    input wire logic [NUM_CORE-1:0] core_high_i,
    input wire logic [NUM_PERIPH-1:0] periph_pend_i,
    input wire logic [NUM_PERIPH-1:0] periph_high_i,
    input wire logic prio_mode_i,
    input wire logic global_high_i,
    input wire logic periph_low_i,
    output logic high_o,
    output logic low_o
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (NUM_CORE < 1 || NUM_PERIPH < 1) begin : g_bad_num
        $error("irq_request_arbiter: source counts must be at least 1");
    end

    // pure combinational so the top sees flag changes in the same cycle
    always_comb begin
        high_o = 1'b0;
        low_o = 1'b0;
        if (!prio_mode_i) begin
            high_o = global_high_i & ((|core_pend_i) | (periph_low_i & (|periph_pend_i)));
        end else begin
            high_o = global_high_i & ((|(core_pend_i & core_high_i))
                | (|(periph_pend_i & periph_high_i)));
            low_o = global_high_i & periph_low_i & ((|(core_pend_i & ~core_high_i))
                | (|(periph_pend_i & ~periph_high_i)));
        end
    end
endmodule // irq_request_arbiter
`default_nettype wire

// >>> design/interrupt_flag_enable_regs.sv
// interrupt control register bank with flags, enables, priorities and request outputs
//
// Summary of operation
// - flags set regardless of any enable
// - compat mode: bit 7 enables all
// - priority mode: bit 7 enables high
// - compat mode: bit 6 gates peripherals
// - priority mode: bit 6 enables low
// - timer, ext0, port enables bits 5-3
// - timer and ext0 flags, software clears
// - port flag set on upper pin change
// - mismatch keeps flag set until read
// - bit 7 disables all port pull-ups
// - edge selects for three external pins
// - timer and port priority bits
// - unimplemented bits read zero, ignore writes
// - ext2 and ext1 priority bits
// - ext2 and ext1 enable bits
// - ext2 and ext1 flags, software clears
// - parallel port access flag, optional
// - conversion done flag, software clears
// - rx full mirrors buffer, read-only
// - tx empty mirrors buffer, read-only
// - sync serial done flag, software clears
// - capture flag only in capture mode
// - reset control bit 7 selects priority
// - vector 0008h high, 0018h low
// - accept clears, return restores bit 7 (bit 6 for low in priority mode)
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module interrupt_flag_enable_regs #(
    parameter bit HAS_PARALLEL_PORT = 1'b1,
    parameter int unsigned UPPER_PINS = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [irq_regs_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // event sources
    input wire logic timer_zero_overflow_i,
    input wire logic [2:0] ext_pins_i,
    input wire logic [UPPER_PINS-1:0] upper_port_pins_i,
    input wire logic port_read_i,
    input wire logic [7:0] port_latch_i,
    input wire logic parallel_port_access_i,
    input wire logic conversion_done_i,
    input wire logic serial_rx_full_i,
    input wire logic serial_tx_empty_i,
    input wire logic sync_serial_done_i,
    input wire logic capture_mode_i,
    input wire logic capture_event_i,
    // peripheral enable and priority held elsewhere
    input wire logic [7:0] periph_enable_i,
    input wire logic [7:0] periph_priority_i,
    // core handshake
    input wire logic irq_accept_i,
    input wire logic irq_return_i,
    input wire logic return_high_i,
    output logic high_req_o,
    output logic low_req_o,
    output logic [15:0] vector_o,
    output logic [7:0] pullup_enable_o
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (UPPER_PINS < 1 || UPPER_PINS > 8) begin : g_bad_pins
        $error("interrupt_flag_enable_regs: UPPER_PINS must be 1 to 8");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    irq_regs_pkg::bus_state_t bus_q; // wishbone answer state
    irq_regs_pkg::bus_state_t bus_d;
    logic [7:0] main_q; // irq_control_main
    logic [7:0] main_d;
    logic [7:0] edges_q; // irq_control_edges_priority
    logic [7:0] edges_d;
    logic [7:0] ext_q; // irq_control_external_pins
    logic [7:0] ext_d;
    logic [7:0] pflag_q; // stored bits of peripheral_flag_bank_one
    logic [7:0] pflag_d;
    logic [7:0] rctl_q; // reset_control_reg
    logic [7:0] rctl_d;
    logic [7:0] pflag_view; // bank one as software sees it
    logic [UPPER_PINS-1:0] port_snap_q; // pin levels at last port read
    logic snap_valid_q; // snapshot taken after reset
    logic mismatch; // upper pins differ from snapshot
    logic [2:0] ext_evt; // edge events on ext pins
    logic [2:0] edge_sel; // rising selects per ext pin
    logic bus_req; // a cycle is being presented
    logic wr_stb; // write takes effect this edge
    logic [7:0] wr_byte; // low byte of write data
    logic [7:0] rd_mux; // selected read value
    logic [4:0] core_pend; // core source flag and enable
    logic [4:0] core_high; // core source priority
    logic [7:0] periph_pend; // peripheral flag and enable
    logic arb_high; // combinational high request
    logic arb_low; // combinational low request
    logic prio_mode; // two-level priority active
    logic [15:0] vector_d;

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    assign bus_req = wb_cyc_i & wb_stb_i;
    // write lands at the edge where ack is seen high
    assign wr_stb = bus_req & wb_we_i & wb_sel_i[0] & (bus_q == irq_regs_pkg::BUS_ACK);
    assign wr_byte = wb_dat_i[7:0];

    // answer state: one wait cycle, then ack for exactly one cycle
    always_comb begin
        bus_d = bus_q;
        case (bus_q)
            irq_regs_pkg::BUS_IDLE: begin
                if (bus_req) begin
                    bus_d = irq_regs_pkg::BUS_ACK;
                end
            end
            irq_regs_pkg::BUS_ACK: begin
                bus_d = irq_regs_pkg::BUS_IDLE;
            end
            default: begin
                bus_d = irq_regs_pkg::BUS_IDLE;
            end
        endcase
    end

    // bus state register and ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_q <= irq_regs_pkg::BUS_IDLE;
            wb_ack_o <= 1'b0;
        end else begin
            bus_q <= bus_d;
            wb_ack_o <= (bus_d == irq_regs_pkg::BUS_ACK);
        end
    end

    // read decode; unmapped offsets read zero but are still acked
    always_comb begin
        case (wb_adr_i)
            irq_regs_pkg::OFS_MAIN: begin
                rd_mux = main_q;
            end
            irq_regs_pkg::OFS_EDGES: begin
                rd_mux = edges_q;
            end
            irq_regs_pkg::OFS_EXT: begin
                rd_mux = ext_q;
            end
            irq_regs_pkg::OFS_PFLAG1: begin
                rd_mux = pflag_view;
            end
            irq_regs_pkg::OFS_RESET_CTRL: begin
                rd_mux = rctl_q;
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // read data captured with the ack so it is a flop output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_req && !wb_we_i && bus_q == irq_regs_pkg::BUS_IDLE) begin
            wb_dat_o <= {24'h000000, rd_mux};
        end
    end

    // ------------------------------------------------------------
    // event sources
    // ------------------------------------------------------------
    // edge selects feed detector
    assign edge_sel = {edges_q[irq_regs_pkg::EDG_EXT2_SEL], edges_q[irq_regs_pkg::EDG_EXT1_SEL],
                       edges_q[irq_regs_pkg::EDG_EXT0_SEL]};

    ext_edge_detect #(
        .NUM(3)
    ) u_edges (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pins_i(ext_pins_i),
        .rising_sel_i(edge_sel),
        .event_o(ext_evt)
    );

    // port snapshot: taken after reset and on every port read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_snap_q <= '0;
            snap_valid_q <= 1'b0;
        end else if (!snap_valid_q || port_read_i) begin
            port_snap_q <= upper_port_pins_i;
            snap_valid_q <= 1'b1;
        end
    end

    assign mismatch = snap_valid_q & (upper_port_pins_i != port_snap_q);

    // ------------------------------------------------------------
    // irq_control_main
    // ------------------------------------------------------------
    // order: software write, then core handshake, then event sets win
    always_comb begin
        main_d = main_q;
        if (wr_stb && wb_adr_i == irq_regs_pkg::OFS_MAIN) begin
            main_d = wr_byte;
        end
        if (irq_accept_i) begin
            if (!prio_mode || high_req_o) begin
                main_d[irq_regs_pkg::MAIN_GLOBAL_HIGH] = 1'b0;
            end else if (low_req_o) begin
                main_d[irq_regs_pkg::MAIN_PERIPH_LOW] = 1'b0;
            end
        end
        if (irq_return_i) begin
            if (!prio_mode || return_high_i) begin
                main_d[irq_regs_pkg::MAIN_GLOBAL_HIGH] = 1'b1;
            end else begin
                main_d[irq_regs_pkg::MAIN_PERIPH_LOW] = 1'b1;
            end
        end
        if (timer_zero_overflow_i) begin
            main_d[irq_regs_pkg::MAIN_TMR0_FLAG] = 1'b1;
        end
        if (ext_evt[0]) begin
            main_d[irq_regs_pkg::MAIN_EXT0_FLAG] = 1'b1;
        end
        if (mismatch) begin
            main_d[irq_regs_pkg::MAIN_PORT_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_q <= irq_regs_pkg::RST_MAIN;
        end else begin
            main_q <= main_d;
        end
    end

    // ------------------------------------------------------------
    // irq_control_edges_priority and reset control
    // ------------------------------------------------------------
    // masked writes, holes stay zero
    always_comb begin
        edges_d = edges_q;
        rctl_d = rctl_q;
        if (wr_stb && wb_adr_i == irq_regs_pkg::OFS_EDGES) begin
            edges_d = wr_byte & irq_regs_pkg::WMASK_EDGES;
        end
        if (wr_stb && wb_adr_i == irq_regs_pkg::OFS_RESET_CTRL) begin
            rctl_d = wr_byte & irq_regs_pkg::WMASK_RESET_CTRL;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edges_q <= irq_regs_pkg::RST_EDGES;
            rctl_q <= irq_regs_pkg::RST_RESET_CTRL;
        end else begin
            edges_q <= edges_d;
            rctl_q <= rctl_d;
        end
    end

    assign prio_mode = rctl_q[irq_regs_pkg::RC_PRIO_MODE];

    // ------------------------------------------------------------
    // irq_control_external_pins
    // ------------------------------------------------------------
    always_comb begin
        ext_d = ext_q;
        if (wr_stb && wb_adr_i == irq_regs_pkg::OFS_EXT) begin
            ext_d = wr_byte & irq_regs_pkg::WMASK_EXT;
        end
        if (ext_evt[1]) begin
            ext_d[irq_regs_pkg::EXT_ONE_FLAG] = 1'b1;
        end
        if (ext_evt[2]) begin
            ext_d[irq_regs_pkg::EXT_TWO_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_q <= irq_regs_pkg::RST_EXT;
        end else begin
            ext_q <= ext_d;
        end
    end

    // ------------------------------------------------------------
    // peripheral_flag_bank_one
    // ------------------------------------------------------------
    // sticky flags, set beats clear
    always_comb begin
        pflag_d = pflag_q;
        if (wr_stb && wb_adr_i == irq_regs_pkg::OFS_PFLAG1) begin
            pflag_d = wr_byte & irq_regs_pkg::WMASK_PFLAG1;
        end
        if (parallel_port_access_i) begin
            pflag_d[irq_regs_pkg::PF_PARALLEL] = 1'b1;
        end
        if (conversion_done_i) begin
            pflag_d[irq_regs_pkg::PF_CONVERSION] = 1'b1;
        end
        if (sync_serial_done_i) begin
            pflag_d[irq_regs_pkg::PF_SYNC_SERIAL] = 1'b1;
        end
        if (capture_mode_i && capture_event_i) begin
            pflag_d[irq_regs_pkg::PF_CAPTURE_ONE] = 1'b1;
        end
        // absent parallel port: bit never holds a one
        if (!HAS_PARALLEL_PORT) begin
            pflag_d[irq_regs_pkg::PF_PARALLEL] = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pflag_q <= irq_regs_pkg::RST_PFLAG1;
        end else begin
            pflag_q <= pflag_d;
        end
    end

    always_comb begin
        pflag_view = pflag_q;
        pflag_view[irq_regs_pkg::PF_RX_FULL] = serial_rx_full_i;
        pflag_view[irq_regs_pkg::PF_TX_EMPTY] = serial_tx_empty_i;
    end

    // ------------------------------------------------------------
    // request formation
    // ------------------------------------------------------------
    // core sources: timer0, ext0, port change, ext1, ext2
    assign core_pend = {
        ext_q[irq_regs_pkg::EXT_TWO_FLAG] & ext_q[irq_regs_pkg::EXT_TWO_EN],
        ext_q[irq_regs_pkg::EXT_ONE_FLAG] & ext_q[irq_regs_pkg::EXT_ONE_EN],
        main_q[irq_regs_pkg::MAIN_PORT_FLAG] & main_q[irq_regs_pkg::MAIN_PORT_EN],
        main_q[irq_regs_pkg::MAIN_EXT0_FLAG] & main_q[irq_regs_pkg::MAIN_EXT0_EN],
        main_q[irq_regs_pkg::MAIN_TMR0_FLAG] & main_q[irq_regs_pkg::MAIN_TMR0_EN]};
    // ext0 has no priority bit and is always high
    assign core_high = {
        ext_q[irq_regs_pkg::EXT_TWO_PRIO],
        ext_q[irq_regs_pkg::EXT_ONE_PRIO],
        edges_q[irq_regs_pkg::EDG_PORT_PRIO],
        1'b1,
        edges_q[irq_regs_pkg::EDG_TMR0_PRIO]};
    assign periph_pend = pflag_view & periph_enable_i;

    irq_request_arbiter #(
        .NUM_CORE(5),
        .NUM_PERIPH(8)
    ) u_arb (
        .core_pend_i(core_pend),
        .core_high_i(core_high),
        .periph_pend_i(periph_pend),
        .periph_high_i(periph_priority_i),
        .prio_mode_i(prio_mode),
        .global_high_i(main_q[irq_regs_pkg::MAIN_GLOBAL_HIGH]),
        .periph_low_i(main_q[irq_regs_pkg::MAIN_PERIPH_LOW]),
        .high_o(arb_high),
        .low_o(arb_low)
    );

    assign vector_d = (arb_high || !prio_mode) ? irq_regs_pkg::VEC_HIGH : irq_regs_pkg::VEC_LOW;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_req_o <= 1'b0;
            low_req_o <= 1'b0;
            vector_o <= irq_regs_pkg::VEC_HIGH;
        end else begin
            high_req_o <= arb_high;
            low_req_o <= arb_low & ~arb_high;
            vector_o <= vector_d;
        end
    end

    // ------------------------------------------------------------
    // port pull-ups
    // ------------------------------------------------------------
    // disable overrides latch values
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pullup_enable_o <= 8'h00;
        end else if (edges_q[irq_regs_pkg::EDG_PULLUP_DIS]) begin
            pullup_enable_o <= 8'h00;
        end else begin
            pullup_enable_o <= port_latch_i;
        end
    end
endmodule // interrupt_flag_enable_regs
`default_nettype wire

// >>> tb/irq_regs_assertions.sv
// port checker of the interrupt register bank
`timescale 1ns/10ps
`default_nettype none
module irq_regs_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic high_req_o,
    input wire logic low_req_o,
    input wire logic [15:0] vector_o,
    input wire logic irq_accept_i,
    input wire logic [7:0] port_latch_i,
    input wire logic [7:0] pullup_enable_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
    dat_upper_a: assert property (wb_dat_o[31:8] == 24'h0) else $error("upper data set");
    dat_hold_a: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o)) else $error("data moved");
    req_excl_a: assert property (!(high_req_o && low_req_o)) else $error("both requests");
    low_vec_a: assert property (low_req_o |-> vector_o == 16'h0018) else $error("low vector");
    accept_drop_a: assert property (irq_accept_i && high_req_o |-> ##[1:2] !high_req_o)
        else $error("request kept after accept");
    pullup_follow_a: assert property (pullup_enable_o != 8'h00 |->
        pullup_enable_o == $past(port_latch_i)) else $error("pull-up not latch");
endmodule // irq_regs_checker
bind interrupt_flag_enable_regs irq_regs_checker chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .wb_dat_o, .high_req_o, .low_req_o, .vector_o, .irq_accept_i, .port_latch_i,
    .pullup_enable_o);
`default_nettype wire

// >>> tb/core_model.sv
// core side: takes each request after zero to two cycles
`timescale 1ns/10ps
`default_nettype none
module core_model (
    input wire logic clk_i,
    input wire logic req_i,
    output logic accept_o
);
    // never returns, so an accepted level stays shut
    always begin
        accept_o <= 1'b0;
        @(posedge clk_i);
        if (req_i === 1'b1) begin
            repeat ($urandom_range(2)) @(posedge clk_i);
            accept_o <= 1'b1;
            @(posedge clk_i);
            accept_o <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
    end
endmodule // core_model
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench of the interrupt register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, irq_accept_i;
    logic timer_zero_overflow_i = 0, port_read_i = 0, capture_mode_i = 0, high_req_o, low_req_o;
    logic serial_rx_full_i = 0, serial_tx_empty_i = 0, irq_return_i = 0;
    logic [2:0] ext_pins_i = 0;
    logic [3:0] upper_port_pins_i = 0, pp = 0;
    logic [4:0] wb_adr_i = 0;
    logic [7:0] port_latch_i = 0, pullup_enable_o, d, m [5] = '{0, 8'hF5, 8'hC0, 0, 0};
    logic [7:0] mk [5] = '{8'hFF, 8'hF5, 8'hDB, 8'hCC, 8'h80};
    logic [15:0] vector_o;
    logic [31:0] wb_dat_i = 0, wb_dat_o;
    int error_cnt = 0, n_tests = 0, cyc_cnt = 0, i, t;
    always #2 clk_i = ~clk_i;
    interrupt_flag_enable_regs uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer_zero_overflow_i, .ext_pins_i,
        .upper_port_pins_i, .port_read_i, .port_latch_i, .parallel_port_access_i(pp[3]),
        .conversion_done_i(pp[2]), .serial_rx_full_i, .serial_tx_empty_i,
        .sync_serial_done_i(pp[1]), .capture_mode_i, .capture_event_i(pp[0]),
        .periph_enable_i(8'h00), .periph_priority_i(8'h00), .irq_accept_i,
        .irq_return_i, .return_high_i(1'b0), .high_req_o, .low_req_o, .vector_o,
        .pullup_enable_o);
    core_model core (.clk_i, .req_i(high_req_o | low_req_o), .accept_o(irq_accept_i));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // one classic cycle; reads are compared with the model
    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] v);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, v};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        if (!w) check(wb_dat_o[7:0], a > 16 ? 8'h0 : m[a / 4] |
            (a == 12 ? {2'b0, serial_rx_full_i, serial_tx_empty_i, 4'h0} : 8'h0));
        else if (a <= 16) m[a / 4] = v & mk[a / 4];
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic wreq(input logic hi, input logic lvl);
        for (t = 0; (hi ? high_req_o : low_req_o) !== lvl && t < 40; t++) @(posedge clk_i);
        check(t < 40, 1);
    endtask
    task automatic tick;
        @(posedge clk_i);
        timer_zero_overflow_i <= 0;
        pp <= 0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic stop_test;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 4000) begin
            error_cnt++;
            stop_test;
        end
    end
    initial begin
        void'($urandom(32'h9f2f25d9));
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        port_latch_i <= $urandom;
        {serial_rx_full_i, serial_tx_empty_i} <= $urandom;
        @(posedge clk_i);
        for (i = 0; i < 6; i++) acc(0, i * 4, 0);
        check(pullup_enable_o, 8'h00);
        for (i = 0; i < 6; i++) begin
            d = $urandom;
            acc(1, i * 4, i == 0 ? d & 8'h3F : d);
            acc(0, i * 4, 0);
        end
        foreach (mk[j]) acc(1, j * 4, j == 1 ? 8'h70 : 8'h00);
        check(pullup_enable_o, port_latch_i);
        // every source fires while all enables are off
        {timer_zero_overflow_i, ext_pins_i, upper_port_pins_i, pp, capture_mode_i} <= 13'h1FFF;
        tick;
        m[0] = 8'h07;
        m[2] = 8'h03;
        m[3] = 8'hCC;
        for (i = 0; i < 4; i++) acc(0, i * 4, 0);
        acc(1, 0, 0);
        m[0] = 8'h01;
        acc(0, 0, 0);
        port_read_i <= 1;
        @(posedge clk_i);
        port_read_i <= 0;
        acc(1, 0, 0);
        acc(1, 8, 0);
        acc(1, 4, 8'h10);
        ext_pins_i <= 0;
        irq_return_i <= 1;
        @(posedge clk_i);
        irq_return_i <= 0;
        m[0] = 8'h82;
        m[2] = 8'h01;
        repeat (2) @(posedge clk_i);
        acc(0, 0, 0);
        acc(0, 8, 0);
        acc(1, 0, 8'hA0);
        timer_zero_overflow_i <= 1;
        @(posedge clk_i);
        timer_zero_overflow_i <= 0;
        wreq(1, 1);
        check(vector_o, 16'h0008);
        wreq(1, 0);
        m[0] = 8'h24;
        acc(0, 0, 0);
        acc(1, 16, 8'h80);
        acc(1, 0, 8'hE4);
        wreq(0, 1);
        check(vector_o, 16'h0018);
        wreq(0, 0);
        m[0] = 8'hA4;
        acc(0, 0, 0);
        stop_test;
    end
endmodule // testbench
`default_nettype wire
